// File: pfms_host_model.sv
// partner model: external reset source, debug host and pin loads
`timescale 1ns/100ps
module pfms_host_model (
  input wire logic i_ref_clk,
  input wire pfms_pkg::pfms_pad_t i_pad,
  input wire logic [5:0] i_host_low,
  output logic [5:0] o_pad_in
);
  // undriven pins toggle so a stale level is never mistaken for a real one
  logic flip = 1'b0;
  always @(posedge i_ref_clk) begin
    flip <= !flip;
  end
  // ----------------------------------------------------------------------
  // wire resolution: device drive, host pulls low, then pull devices
  // ----------------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 6; i++) begin
      if (i_pad.oe[i]) o_pad_in[i] = i_pad.out[i];
      else if (i_host_low[i]) o_pad_in[i] = 1'b0;
      else if (i_pad.pull_up[i]) o_pad_in[i] = 1'b1;
      else if (i_pad.pull_down[i]) o_pad_in[i] = 1'b0;
      else o_pad_in[i] = flip;
    end
  end
endmodule

// File: pfms_pkg.sv
// package: constants and carriers for the pin function and mode select block
package pfms_pkg;

  // ----------------------------------------------------------------------
  // widths and counts
  // ----------------------------------------------------------------------
  localparam int unsigned PFMS_PINS = 6;
  localparam int unsigned PFMS_BIT_CYCLES = 16;
  localparam int unsigned PFMS_CNT_W = 4;
  localparam int unsigned PFMS_SPEEDUP_CYCLES = 1;

  // ----------------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------------
  localparam logic PFMS_RST_PIN_EN_RESET = 1'h0;
  localparam logic PFMS_DBG_PIN_EN_RESET = 1'h1;
  localparam logic PFMS_BG_MODE_RESET = 1'h0;
  localparam logic [5:0] PFMS_PORT_ZERO = 6'h00;

  // ----------------------------------------------------------------------
  // pin indices
  // ----------------------------------------------------------------------
  localparam int unsigned PFMS_PIN_RST = 2;
  localparam int unsigned PFMS_PIN_DBG = 3;

  // debug pin function selection, lowest priority first
  typedef enum logic [1:0] {
    PFMS_FN_PORT = 2'h0,
    PFMS_FN_CMP = 2'h1,
    PFMS_FN_DEBUG = 2'h3
  } pfms_fn_t;

  // per-pin drive bundle towards the pad
  typedef struct packed {
    logic [5:0] out;
    logic [5:0] oe;
    logic [5:0] pull_up;
    logic [5:0] pull_down;
  } pfms_pad_t;

  // pad controls in reset: only the strap pin keeps its pullup
  localparam pfms_pad_t PFMS_PAD_RESET = '{out: 6'h00, oe: 6'h00, pull_up: 6'h08,
    pull_down: 6'h00};

  // software port configuration
  typedef struct packed {
    logic [5:0] data;
    logic [5:0] dir_out;
    logic [5:0] pull_en;
    logic [5:0] pull_is_down;
  } pfms_port_cfg_t;

endpackage

// File: pfms_top.sv
// module: pin function mux, reset pin switch and mode strap for a small mcu
`timescale 1ns/100ps

// Summary of operation
// - bus clock is the internal clock source divided by two, paces the debug serial timing
// - after power-on the reset-capable pin is a plain input bit
// - setting reset_pin_enable makes it the reset input until power-on
// - pullup forced on while that pin is the reset input, the device is out of reset and no programming voltage is present
// - driving the enabled reset pin low resets the device
// - debug pin is mode strap in reset, debug line right after
// - pullup on while debug pin serves debug or mode function
// - debug pin is output port only once debug_pin_enable is cleared
// - strap high at reset release selects normal run mode
// - strap low through power-on reset selects background mode
// - each debug serial bit lasts sixteen debug controller clocks
// - debug controller clock runs at the bus clock rate
// - releasing the debug line high in a 1 bit drives a brief speedup pulse; a 0 bit releases without one
// - after reset shared pins are inputs without pulls, except the debug pin pullup
// - reset-capable pin never drives; carries wake and timer clock inputs
// - debug pin port use is output only; carries comparator output
// - keypad inputs only wake from stop or wait
// - pull devices chosen per pin by port configuration
// - highest-priority enabled function wins, port use lowest
// - programming voltage disables the reset pin pulls
module pfms_top (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_por,
  input wire logic i_system_options_register_wr,
  input wire logic i_system_options_register_reset_pin_enable,
  input wire logic i_system_options_register_debug_pin_enable,
  input wire pfms_pkg::pfms_port_cfg_t i_port_cfg,
  input wire logic [5:0] i_pad_in,
  input wire logic i_vpp_present,
  input wire logic i_cmp_out_en,
  input wire logic i_comparator_output,
  input wire logic i_cmp_inputs_en,
  input wire logic [5:0] i_keypad_en,
  input wire logic i_low_power,
  input wire logic i_dbg_tx_en,
  input wire logic i_dbg_tx_bit,
  output logic o_bus_clk_en,
  output pfms_pkg::pfms_pad_t o_pad,
  output logic [5:0] o_port_in,
  output logic o_reset_pin_enable,
  output logic o_debug_pin_enable,
  output logic o_ext_reset_req,
  output logic o_background_mode,
  output logic o_keypad_wake,
  output logic o_timer_external_clock_in,
  output logic o_dbg_rx_bit,
  output logic o_dbg_rx_valid,
  output logic o_dbg_tx_busy
);

  // ----------------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------------
  logic [5:0] pad_s1;
  logic [5:0] pad_s2;
  logic vpp_s1;
  logic vpp_s2;
  logic [5:0] next_pad_s1;
  logic [5:0] next_pad_s2;
  logic next_vpp_s1;
  logic next_vpp_s2;

  always_comb begin
    next_pad_s1 = i_pad_in;
    next_pad_s2 = pad_s1;
    next_vpp_s1 = i_vpp_present;
    next_vpp_s2 = vpp_s1;
  end

  // no reset here: the strap level must already be synced when reset rises
  always_ff @(posedge i_ref_clk) begin
    pad_s1 <= next_pad_s1;
    pad_s2 <= next_pad_s2;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      vpp_s1 <= 1'h0;
      vpp_s2 <= 1'h0;
    end else begin
      vpp_s1 <= next_vpp_s1;
      vpp_s2 <= next_vpp_s2;
    end
  end

  // ----------------------------------------------------------------------
  // bus clock divider and option bits
  // ----------------------------------------------------------------------
  // i_rst_n covers every reset; i_por marks power-on, which alone clears
  // the sticky reset pin enable
  logic bus_phase;
  logic rst_pin_en;
  logic dbg_pin_en;
  logic strap_armed;
  logic bg_mode;
  logic next_bus_phase;
  logic next_rst_pin_en;
  logic next_dbg_pin_en;
  logic next_strap_armed;
  logic next_bg_mode;

  always_comb begin
    next_bus_phase = ~bus_phase;
    next_rst_pin_en = rst_pin_en;
    if (i_por) begin
      next_rst_pin_en = pfms_pkg::PFMS_RST_PIN_EN_RESET;
    end else if (i_system_options_register_wr && i_system_options_register_reset_pin_enable) begin
      next_rst_pin_en = 1'h1;
    end
    next_dbg_pin_en = dbg_pin_en;
    if (i_system_options_register_wr) begin
      next_dbg_pin_en = i_system_options_register_debug_pin_enable;
    end
    // strap caught on the first clock after release, from the synced pad
    next_strap_armed = 1'h0;
    next_bg_mode = bg_mode;
    if (strap_armed) begin
      next_bg_mode = ~pad_s2[pfms_pkg::PFMS_PIN_DBG];
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bus_phase <= 1'h0;
      dbg_pin_en <= pfms_pkg::PFMS_DBG_PIN_EN_RESET;
      strap_armed <= 1'h1;
      bg_mode <= pfms_pkg::PFMS_BG_MODE_RESET;
    end else begin
      bus_phase <= next_bus_phase;
      dbg_pin_en <= next_dbg_pin_en;
      strap_armed <= next_strap_armed;
      bg_mode <= next_bg_mode;
    end
  end

  // sticky bit must survive a pin reset, so only power-on clears it
  always_ff @(posedge i_ref_clk) begin
    rst_pin_en <= next_rst_pin_en;
  end

  // ----------------------------------------------------------------------
  // debug serial bit timing
  // ----------------------------------------------------------------------
  // counter advances on bus clock phases only, so bits track the bus rate
  logic [pfms_pkg::PFMS_CNT_W-1:0] bit_cnt;
  logic tx_active;
  logic tx_bit;
  logic speedup;
  logic [pfms_pkg::PFMS_CNT_W-1:0] next_bit_cnt;
  logic next_tx_active;
  logic next_tx_bit;
  logic next_speedup;
  logic bit_end;

  always_comb begin
    bit_end = bus_phase && (bit_cnt == 4'(pfms_pkg::PFMS_BIT_CYCLES - 1));
    next_bit_cnt = bit_cnt;
    next_tx_active = tx_active;
    next_tx_bit = tx_bit;
    next_speedup = 1'h0;
    if (!tx_active) begin
      next_bit_cnt = 4'h0;
      // start only on a bus phase, so every bit spans the same ref clocks
      if (i_dbg_tx_en && dbg_pin_en && bus_phase) begin
        next_tx_active = 1'h1;
        next_tx_bit = i_dbg_tx_bit;
      end
    end else if (bus_phase) begin
      next_bit_cnt = bit_cnt + 4'h1;
      // low part of a 1 bit, then release high with a speedup pulse
      if (bit_cnt == 4'h3 && tx_bit) begin
        next_speedup = 1'h1;
      end
      if (bit_end) begin
        next_tx_active = 1'h0;
      end
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      bit_cnt <= 4'h0;
      tx_active <= 1'h0;
      tx_bit <= 1'h0;
      speedup <= 1'h0;
    end else begin
      bit_cnt <= next_bit_cnt;
      tx_active <= next_tx_active;
      tx_bit <= next_tx_bit;
      speedup <= next_speedup;
    end
  end

  // ----------------------------------------------------------------------
  // pad function mux
  // ----------------------------------------------------------------------
  pfms_pkg::pfms_pad_t next_pad;
  pfms_pkg::pfms_fn_t dbg_fn;
  logic dbg_drive_low;
  logic [5:0] next_port_in;
  logic next_ext_reset_req;
  logic next_keypad_wake;
  logic next_rx_valid;

  always_comb begin
    // reset value of cfg leaves all pins as pull-free inputs
    next_pad.out = i_port_cfg.data;
    next_pad.oe = i_port_cfg.dir_out;
    next_pad.pull_up = i_port_cfg.pull_en & ~i_port_cfg.pull_is_down;
    next_pad.pull_down = i_port_cfg.pull_en & i_port_cfg.pull_is_down;
    // comparator inputs are analog; they take the digital driver away
    if (i_cmp_inputs_en) begin
      next_pad.oe[1:0] = 2'h0;
    end
    // reset-capable pin is input only
    next_pad.oe[pfms_pkg::PFMS_PIN_RST] = 1'h0;
    if (rst_pin_en) begin
      next_pad.pull_up[pfms_pkg::PFMS_PIN_RST] = 1'h1;
      next_pad.pull_down[pfms_pkg::PFMS_PIN_RST] = 1'h0;
    end
    if (vpp_s2) begin
      next_pad.pull_up[pfms_pkg::PFMS_PIN_RST] = 1'h0;
      next_pad.pull_down[pfms_pkg::PFMS_PIN_RST] = 1'h0;
    end
    // debug pin: highest enabled function wins
    if (dbg_pin_en) begin
      dbg_fn = pfms_pkg::PFMS_FN_DEBUG;
    end else if (i_cmp_out_en) begin
      dbg_fn = pfms_pkg::PFMS_FN_CMP;
    end else begin
      dbg_fn = pfms_pkg::PFMS_FN_PORT;
    end
    dbg_drive_low = tx_active && !tx_bit && !bit_cnt[3];
    case (dbg_fn)
      pfms_pkg::PFMS_FN_DEBUG: begin
        // pseudo open drain: drive low, or high only for the speedup pulse
        // speedup comes from its register, right after the low part ends
        next_pad.out[pfms_pkg::PFMS_PIN_DBG] = speedup;
        next_pad.oe[pfms_pkg::PFMS_PIN_DBG] = (tx_active && bit_cnt < 4'h4) || speedup;
        if (tx_active && bit_cnt >= 4'h4 && bit_cnt < 4'h8 && !tx_bit) begin
          next_pad.oe[pfms_pkg::PFMS_PIN_DBG] = 1'h1;
        end
        if (!dbg_drive_low && !speedup && bit_cnt >= 4'h4) begin
          next_pad.oe[pfms_pkg::PFMS_PIN_DBG] = 1'h0;
        end
        next_pad.pull_up[pfms_pkg::PFMS_PIN_DBG] = 1'h1;
      end
      pfms_pkg::PFMS_FN_CMP: begin
        next_pad.out[pfms_pkg::PFMS_PIN_DBG] = i_comparator_output;
        next_pad.oe[pfms_pkg::PFMS_PIN_DBG] = 1'h1;
        next_pad.pull_up[pfms_pkg::PFMS_PIN_DBG] = 1'h0;
      end
      default: begin
        next_pad.oe[pfms_pkg::PFMS_PIN_DBG] = 1'h1;
        next_pad.pull_up[pfms_pkg::PFMS_PIN_DBG] = 1'h0;
      end
    endcase
    next_pad.pull_down[pfms_pkg::PFMS_PIN_DBG] = 1'h0;
    next_port_in = pad_s2;
    next_port_in[pfms_pkg::PFMS_PIN_DBG] = 1'h0;
    next_ext_reset_req = rst_pin_en && !pad_s2[pfms_pkg::PFMS_PIN_RST];
    // keypad only matters while the core sleeps
    next_keypad_wake = i_low_power && |(i_keypad_en & ~pad_s2);
    next_rx_valid = dbg_pin_en && !tx_active && bus_phase;
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_pad <= pfms_pkg::PFMS_PAD_RESET;
      o_port_in <= pfms_pkg::PFMS_PORT_ZERO;
      o_ext_reset_req <= 1'h0;
      o_keypad_wake <= 1'h0;
      o_timer_external_clock_in <= 1'h0;
      o_dbg_rx_bit <= 1'h1;
      o_dbg_rx_valid <= 1'h0;
      o_bus_clk_en <= 1'h0;
      o_reset_pin_enable <= 1'h0;
      o_debug_pin_enable <= pfms_pkg::PFMS_DBG_PIN_EN_RESET;
      o_background_mode <= pfms_pkg::PFMS_BG_MODE_RESET;
      o_dbg_tx_busy <= 1'h0;
    end else begin
      o_pad <= next_pad;
      o_port_in <= next_port_in;
      o_ext_reset_req <= next_ext_reset_req;
      o_keypad_wake <= next_keypad_wake;
      o_timer_external_clock_in <= pad_s2[pfms_pkg::PFMS_PIN_RST];
      o_dbg_rx_bit <= pad_s2[pfms_pkg::PFMS_PIN_DBG];
      o_dbg_rx_valid <= next_rx_valid;
      o_bus_clk_en <= next_bus_phase;
      o_reset_pin_enable <= rst_pin_en;
      o_debug_pin_enable <= dbg_pin_en;
      o_background_mode <= bg_mode;
      o_dbg_tx_busy <= tx_active;
    end
  end

endmodule

// File: pfms_top_chk.sv
// checker: port-level assertions for the pin function block
`timescale 1ns/100ps
module pfms_top_chk (
  input wire logic i_ref_clk,
  input wire logic i_rst_n,
  input wire logic i_por,
  input wire logic i_system_options_register_wr,
  input wire logic i_system_options_register_reset_pin_enable,
  input wire logic i_system_options_register_debug_pin_enable,
  input wire logic i_vpp_present,
  input wire logic i_low_power,
  input wire logic o_bus_clk_en,
  input wire pfms_pkg::pfms_pad_t o_pad,
  input wire logic o_reset_pin_enable,
  input wire logic o_debug_pin_enable,
  input wire logic o_keypad_wake,
  input wire logic o_dbg_tx_busy
);
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);
  logic [7:0] busy_len;
  logic [7:0] next_busy_len;
  always_comb next_busy_len = o_dbg_tx_busy ? busy_len + 8'h01 : 8'h00;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) busy_len <= 8'h00;
    else busy_len <= next_busy_len;
  end
  sequence s_rpe_wr;
    i_system_options_register_wr && i_system_options_register_reset_pin_enable && !i_por;
  endsequence
  sequence s_dpe_clr;
    i_system_options_register_wr && !i_system_options_register_debug_pin_enable;
  endsequence
  AST_BUS_HALF: assert property (o_bus_clk_en |=> !o_bus_clk_en ##1 o_bus_clk_en)
    else $error("bus clock phase not half rate");
  AST_RPE_SET: assert property (s_rpe_wr |-> ##2 o_reset_pin_enable)
    else $error("reset pin enable not set");
  AST_RPE_STICK: assert property (o_reset_pin_enable && !i_por && !$past(i_por) |=> o_reset_pin_enable)
    else $error("reset pin enable dropped");
  AST_RST_PULL: assert property (o_reset_pin_enable && !i_vpp_present
    && !$past(i_vpp_present, 4) |-> o_pad.pull_up[2] && !o_pad.pull_down[2])
    else $error("reset pin pullup missing");
  AST_RST_NODRV: assert property (!o_pad.oe[2])
    else $error("reset pin driven");
  AST_DBG_PULL: assert property (o_debug_pin_enable && $past(i_rst_n)
    && !$past(i_system_options_register_wr) && !$past(i_system_options_register_wr, 2) |-> o_pad.pull_up[3])
    else $error("debug pin pullup missing");
  AST_DPE_CLR: assert property (s_dpe_clr |-> ##2 !o_debug_pin_enable)
    else $error("debug pin enable not cleared");
  AST_TX_LEN: assert property ($fell(o_dbg_tx_busy) |-> busy_len == 8'h20)
    else $error("debug bit length wrong");
  AST_WAKE: assert property (!$past(i_low_power) && !$past(i_low_power, 2)
    && !$past(i_low_power, 3) |-> !o_keypad_wake)
    else $error("wake outside low power");
endmodule
bind pfms_top pfms_top_chk u_chk (.i_ref_clk(i_ref_clk), .i_rst_n(i_rst_n), .i_por(i_por),
  .i_system_options_register_wr(i_system_options_register_wr), .i_system_options_register_reset_pin_enable(i_system_options_register_reset_pin_enable),
  .i_system_options_register_debug_pin_enable(i_system_options_register_debug_pin_enable), .i_vpp_present(i_vpp_present),
  .i_low_power(i_low_power), .o_bus_clk_en(o_bus_clk_en), .o_pad(o_pad),
  .o_reset_pin_enable(o_reset_pin_enable), .o_debug_pin_enable(o_debug_pin_enable),
  .o_keypad_wake(o_keypad_wake), .o_dbg_tx_busy(o_dbg_tx_busy));

// File: tb_pfms_top.sv
// testbench: scenarios for the pin function and mode select block
`timescale 1ns/100ps
module tb_pfms_top;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic por = 1'b1;
  logic wr = 1'b0;
  logic wr_rpe = 1'b0;
  logic wr_dpe = 1'b1;
  logic vpp = 1'b0;
  logic low_pwr = 1'b0;
  logic tx_en = 1'b0;
  logic tx_bit = 1'b0;
  logic [5:0] kb_en = 6'h00;
  logic [5:0] host_low = 6'h00;
  logic [5:0] pad_in;
  pfms_pkg::pfms_port_cfg_t cfg = '0;
  pfms_pkg::pfms_pad_t pad;
  logic bclk, rpe, dpe, ext_req, bg, wake, busy;
  logic timer_external_clock_in, rx_bit, rx_valid;
  logic [5:0] port_in;
  logic cmp_en = 1'b0;
  logic cmp_val = 1'b0;
  logic cmp_in_en = 1'b0;
  int compares = 0;
  int bad_count = 0;
  always #10 clk = ~clk;
  pfms_top u_dut (.i_ref_clk(clk), .i_rst_n(rst_n), .i_por(por), .i_system_options_register_wr(wr),
    .i_system_options_register_reset_pin_enable(wr_rpe), .i_system_options_register_debug_pin_enable(wr_dpe), .i_port_cfg(cfg),
    .i_pad_in(pad_in), .i_vpp_present(vpp), .i_cmp_out_en(cmp_en),
    .i_comparator_output(cmp_val), .i_cmp_inputs_en(cmp_in_en), .i_keypad_en(kb_en),
    .i_low_power(low_pwr), .i_dbg_tx_en(tx_en),
    .i_dbg_tx_bit(tx_bit), .o_bus_clk_en(bclk), .o_pad(pad), .o_port_in(port_in),
    .o_reset_pin_enable(rpe), .o_debug_pin_enable(dpe), .o_ext_reset_req(ext_req),
    .o_background_mode(bg), .o_keypad_wake(wake), .o_timer_external_clock_in(timer_external_clock_in),
    .o_dbg_rx_bit(rx_bit), .o_dbg_rx_valid(rx_valid), .o_dbg_tx_busy(busy));
  pfms_host_model u_host (.i_ref_clk(clk), .i_pad(pad), .i_host_low(host_low), .o_pad_in(pad_in));
  // ----------------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic seen, input logic exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %0t seen %b expected %b", $time, seen, exp);
    end
  endtask
  task automatic finish_test;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask
  // strap held through reset and five cycles past release
  task automatic power_on(input logic strap_low);
    @(posedge clk);
    rst_n <= 1'b0;
    por <= 1'b1;
    host_low[3] <= strap_low;
    wait_clk(12);
    rst_n <= 1'b1;
    por <= 1'b0;
    wait_clk(5);
    host_low[3] <= 1'b0;
  endtask
  task automatic system_options_register_write(input logic rpe_v, input logic dpe_v);
    @(posedge clk);
    wr <= 1'b1;
    wr_rpe <= rpe_v;
    wr_dpe <= dpe_v;
    @(posedge clk);
    wr <= 1'b0;
    wait_clk(3);
  endtask
  task automatic send_bit(input logic b);
    logic [7:0] lo;
    logic [7:0] hi;
    lo = 8'h00;
    hi = 8'h00;
    @(posedge clk);
    tx_en <= 1'b1;
    tx_bit <= b;
    // request held until busy answers it
    repeat (48) begin
      @(posedge clk);
      if (busy) tx_en <= 1'b0;
      if (pad.oe[3] && !pad.out[3]) lo++;
      if (pad.oe[3] && pad.out[3]) hi++;
    end
    check(lo === (b ? 8'h08 : 8'h10), 1'b1);
    if (b) check(hi === 8'h01, 1'b1);
  endtask
  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_defaults;
    power_on(1'b1);
    check(bg, 1'b1);
    check(rpe, 1'b0);
    check(dpe, 1'b1);
    check(((pad.oe | pad.pull_up | pad.pull_down) & 6'h37) === 6'h00, 1'b1);
  endtask
  task automatic t_pulls;
    cfg.pull_en <= 6'h33;
    cfg.pull_is_down <= 6'h11;
    wait_clk(5);
    check((port_in & 6'h33) === 6'h22, 1'b1);
    check((pad.pull_down & 6'h37) === 6'h11, 1'b1);
    check((pad.pull_up & 6'h37) === 6'h22, 1'b1);
    cfg <= '0;
  endtask
  task automatic t_reset_pin;
    system_options_register_write(1'b1, 1'b1);
    check(rpe, 1'b1);
    check(pad.pull_up[2], 1'b1);
    system_options_register_write(1'b0, 1'b1);
    check(rpe, 1'b1);
    host_low[2] <= 1'b1;
    wait_clk(5);
    check(ext_req, 1'b1);
    check(timer_external_clock_in, 1'b0);
    host_low[2] <= 1'b0;
    vpp <= 1'b1;
    wait_clk(5);
    check(pad.pull_up[2] | pad.pull_down[2], 1'b0);
    vpp <= 1'b0;
    wait_clk(7);
    check(timer_external_clock_in, 1'b1);
  endtask
  task automatic t_strap_high;
    logic v;
    logic b;
    power_on(1'b0);
    check(bg, 1'b0);
    check(rpe, 1'b0);
    check(pad.pull_up[3], 1'b1);
    check(rx_bit, 1'b1);
    v = rx_valid;
    b = bclk;
    wait_clk(1);
    check(v ^ rx_valid, 1'b1);
    check(b ^ bclk, 1'b1);
  endtask
  task automatic t_port_out;
    system_options_register_write(1'b0, 1'b0);
    cfg.data <= 6'h08;
    cfg.dir_out <= 6'h08;
    wait_clk(4);
    check(dpe, 1'b0);
    check(pad.oe[3] & pad.out[3], 1'b1);
    cfg.data <= 6'h00;
    wait_clk(4);
    check(pad.out[3], 1'b0);
  endtask
  task automatic t_cmp;
    cmp_en <= 1'b1;
    cmp_val <= 1'b1;
    wait_clk(3);
    check(pad.oe[3] & pad.out[3] & !pad.pull_up[3], 1'b1);
    cmp_val <= 1'b0;
    wait_clk(3);
    check(pad.out[3], 1'b0);
    cmp_en <= 1'b0;
    cfg.dir_out <= 6'h03;
    cmp_in_en <= 1'b1;
    wait_clk(3);
    check(|pad.oe[1:0], 1'b0);
    cmp_in_en <= 1'b0;
    wait_clk(3);
    check(&pad.oe[1:0], 1'b1);
    cfg <= '0;
  endtask
  task automatic t_wake;
    kb_en <= 6'h01;
    host_low[0] <= 1'b1;
    wait_clk(6);
    check(wake, 1'b0);
    low_pwr <= 1'b1;
    wait_clk(6);
    check(wake, 1'b1);
    low_pwr <= 1'b0;
    host_low[0] <= 1'b0;
    wait_clk(3);
    check(wake, 1'b0);
  endtask
  initial begin
    t_defaults();
    t_pulls();
    t_reset_pin();
    t_strap_high();
    send_bit(1'b1);
    send_bit(1'b0);
    t_port_out();
    t_cmp();
    t_wake();
    finish_test();
  end
  initial begin
    wait_clk(20000);
    bad_count++;
    finish_test();
  end
endmodule
